// *** hdl/earom_dev.sv ***
`timescale 1ns/1ps
// Purpose: Word-store end: mode decode, address/data registers, 100x14 store
// Assumes: Serial clock and mode pins come from another party, so synchronised
// Notes:   Acts once per rising edge of the serial clock
module earom_dev
  import earom_pkg::*;
(
  // System
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Link
  earom_link_if.dev                  link,
  // Observation
  output logic       [2:0]           cur_mode,
  output logic                       addr_ok,
  output logic       [WORD_W-1:0]    data_word
);
  logic [2:0]          clk_sync_r;
  logic [1:0]          dat_sync_r;
  logic [2:0]          mode_s1_r;
  logic [2:0]          mode_s2_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [WORD_W-1:0]   data_r;
  logic [WORD_W-1:0]   mem_r [WORDS];
  logic                ser_rise;
  logic                pin_in;
  mode_t               mode;
  logic [INDEX_W-1:0]  index;
  logic                index_ok;

  // One-hot field to position; flags anything not exactly one bit
  function automatic logic [4:0] field_pos(input logic [FIELD_W-1:0] f);
    logic [4:0] r;
    logic [3:0] n;
    r = 5'h00;
    n = 4'h0;
    for (int i = 0; i < FIELD_W; i++) begin
      if (f[i]) begin
        r = {1'b0, 4'(i)};
        n = n + 4'h1;
      end
    end
    if (n != 4'h1) begin
      r = 5'h10;
    end
    return r;
  endfunction

  // Two-flop synchronisers; third clock flop is only for edge detect
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_sync_r <= 3'h0;
      dat_sync_r <= 2'h0;
      mode_s1_r  <= 3'h0;
      mode_s2_r  <= 3'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], link.ser_clk};
      dat_sync_r <= {dat_sync_r[0], link.dat};
      mode_s1_r  <= {link.mode_select_a, link.mode_select_b, link.mode_select_c};
      mode_s2_r  <= mode_s1_r;
    end
  end

  assign ser_rise = clk_sync_r[1] & ~clk_sync_r[2];
  assign pin_in   = dat_sync_r[1];
  assign mode     = mode_t'(mode_s2_r);

  // Tens field arrives first, so it sits in the upper half
  always_comb begin
    logic [4:0] hi;
    logic [4:0] lo;
    hi       = field_pos(addr_r[ADDR_W-1:FIELD_W]);
    lo       = field_pos(addr_r[FIELD_W-1:0]);
    index_ok = ~hi[4] & ~lo[4];
    index    = INDEX_W'(hi[3:0]) * 7'd10 + INDEX_W'(lo[3:0]);
  end

  // Address register moves only in accept-address mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_r <= ADDR_RST;
    end else if (ser_rise && mode == MODE_ACC_ADDR) begin
      addr_r <= {addr_r[ADDR_W-2:0], pin_in};
    end
  end
  // Standby, unused and data accept fall through and hold it

  // Data register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_r <= DATA_RST;
    end else if (ser_rise) begin
      case (mode)
        MODE_ACC_DATA: begin
          data_r <= {data_r[WORD_W-2:0], pin_in};
        end
        MODE_READ: begin
          if (index_ok) begin
            data_r <= mem_r[index];
          end
        end
        MODE_SHIFT: begin
          data_r <= {data_r[WORD_W-2:0], 1'b0};
        end
        default: begin
          data_r <= data_r;
        end
      endcase
    end
  end

  // Store has no reset: it is non-volatile by nature
  always_ff @(posedge clock) begin
    if (ser_rise && index_ok) begin
      if (mode == MODE_ERASE) begin
        mem_r[index] <= '0;
      end else if (mode == MODE_WRITE) begin
        mem_r[index] <= data_r;
      end
    end
  end

  // Driver on only in shift-out; off in every other mode
  assign link.dev_dat_oe = (mode == MODE_SHIFT);
  assign link.dev_dat_o  = data_r[WORD_W-1];

  assign cur_mode  = mode_s2_r;
  assign addr_ok   = index_ok;
  assign data_word = data_r;
endmodule

// *** hdl/earom_host.sv ***
`timescale 1ns/1ps
// Purpose: Host end: makes the serial clock and sequences each operation
// Assumes: Word store acts on the rising edge; host changes pins on the fall
// Notes:   Read data waits in a FIFO; a full FIFO stalls a read at its push, and so later commands
module earom_fifo #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_r [DEPTH];
  logic [PW-1:0]    wr_r;
  logic [PW-1:0]    rd_r;
  logic [PW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = buf_r[rd_r];

  always_ff @(posedge clock) begin
    if (push) begin
      buf_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module earom_host
  import earom_pkg::*;
#(
  parameter int unsigned HALF_CYC = SER_HALF_CYC
) (
  // System
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Link
  earom_link_if.host                link,
  // Command
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  wire mode_t                cmd_op,
  input  wire logic [INDEX_W-1:0]   cmd_addr,
  input  wire logic [WORD_W-1:0]    cmd_wdata,
  // Read data
  output logic                      rsp_valid,
  input  wire logic                 rsp_ready,
  output logic      [WORD_W-1:0]    rsp_data
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_DATA  = 7'h04,
    ST_OPER  = 7'h08,
    ST_SHOUT = 7'h10,
    ST_PUSH  = 7'h20,
    ST_FIN   = 7'h40
  } host_st_t;

  host_st_t          st_r;
  logic [31:0]       div_r;
  logic              sclk_r;
  logic              rise;
  logic              fall;
  logic [1:0]        pin_sync_r;
  logic [ADDR_W-1:0] sh_r;
  logic [WORD_W-1:0] rx_r;
  logic [4:0]        cnt_r;
  mode_t             op_r;
  mode_t             mode_r;
  logic              oe_r;
  logic              push_ready;
  logic              take;

  // Serial clock divider
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_r  <= '0;
      sclk_r <= 1'b0;
    end else if (div_r == HALF_CYC - 1) begin
      div_r  <= '0;
      sclk_r <= ~sclk_r;
    end else begin
      div_r <= div_r + 1;
    end
  end
  assign rise = (div_r == HALF_CYC - 1) & ~sclk_r;
  assign fall = (div_r == HALF_CYC - 1) & sclk_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], link.dat};
    end
  end

  assign cmd_ready = (st_r == ST_IDLE);
  assign take      = cmd_valid & cmd_ready;

  // Pins change on the fall so they are settled at the store's rise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r   <= ST_IDLE;
      sh_r   <= ADDR_RST;
      rx_r   <= DATA_RST;
      cnt_r  <= 5'h00;
      op_r   <= MODE_STANDBY;
      mode_r <= MODE_STANDBY;
      oe_r   <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (take) begin
            // Two one-of-ten codes, tens first
            sh_r  <= {FIELD_W'(1) << (cmd_addr / 7'd10),
                      FIELD_W'(1) << (cmd_addr % 7'd10)};
            op_r  <= cmd_op;
            cnt_r <= 5'(ADDR_W - 1);
            st_r  <= ST_ADDR;
          end
        end
        ST_ADDR, ST_DATA: begin
          if (fall) begin
            if (!oe_r) begin
              // First fall shows the top bit unshifted, or it would be lost
              mode_r <= MODE_ACC_ADDR;
              oe_r   <= 1'b1;
            end else if (cnt_r != 5'h00) begin
              sh_r  <= {sh_r[ADDR_W-2:0], 1'b0};
              cnt_r <= cnt_r - 5'h01;
            end else if (st_r == ST_ADDR && op_r == MODE_WRITE) begin
              // Last address bit was taken at the rise just past
              mode_r <= MODE_ACC_DATA;
              sh_r   <= {cmd_wdata, 6'h00};
              cnt_r  <= 5'(WORD_W - 1);
              st_r   <= ST_DATA;
            end else begin
              mode_r <= op_r;
              oe_r   <= 1'b0;
              st_r   <= ST_OPER;
            end
          end
        end
        ST_OPER: begin
          if (fall) begin
            if (op_r == MODE_READ) begin
              mode_r <= MODE_SHIFT;
              cnt_r  <= 5'(WORD_W - 1);
              st_r   <= ST_SHOUT;
            end else begin
              mode_r <= MODE_STANDBY;
              st_r   <= ST_IDLE;
            end
          end
        end
        ST_SHOUT: begin
          if (rise) begin
            rx_r  <= {rx_r[WORD_W-2:0], pin_sync_r[1]};
            cnt_r <= cnt_r - 5'h01;
            if (cnt_r == 5'h00) begin
              st_r <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          if (push_ready) begin
            st_r <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (fall) begin
            mode_r <= MODE_STANDBY;
            st_r   <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Data register is loaded MSB first, so first sh bit is word bit 13
  // Held low while released, so a command load never moves the pin
  assign link.host_dat_o   = sh_r[ADDR_W-1] & oe_r;
  assign link.host_dat_oe  = oe_r;
  assign link.ser_clk      = sclk_r;
  assign link.mode_select_a = mode_r[2];
  assign link.mode_select_b = mode_r[1];
  assign link.mode_select_c = mode_r[0];

  // Full FIFO holds the machine in ST_PUSH, which keeps cmd_ready low
  earom_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (st_r == ST_PUSH),
    .in_ready  (push_ready),
    .in_data   (rx_r),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );
endmodule

// *** hdl/earom_link_if.sv ***
`timescale 1ns/1ps
// Purpose: Pin bundle between host controller and word store
// Assumes: Undriven data pin reads high, as with a pull-up
// Notes:   Resolves the shared pin from the two enables
interface earom_link_if;
  logic ser_clk;
  logic mode_select_a;
  logic mode_select_b;
  logic mode_select_c;
  logic factory_test_pin;
  logic host_dat_o;
  logic host_dat_oe;
  logic dev_dat_o;
  logic dev_dat_oe;
  logic dat;

  // Both driving at once is a host fault; the device wins here
  assign dat = dev_dat_oe ? dev_dat_o : (host_dat_oe ? host_dat_o : 1'b1);

  modport host (
    output ser_clk, mode_select_a, mode_select_b, mode_select_c,
    output host_dat_o, host_dat_oe,
    input  dat
  );
  modport dev (
    input  ser_clk, mode_select_a, mode_select_b, mode_select_c,
    input  factory_test_pin,
    output dev_dat_o, dev_dat_oe,
    input  dat
  );
endinterface

// *** hdl/earom_pkg.sv ***
// Purpose: Shared constants and types for the serial word-store link
// Assumes: One system clock at 125 MHz; serial clock made by the host end
// Notes:   Mode code bit 2 is mode_select_a, bit 0 is mode_select_c
// Functional notes
// - Store holds 100 words of 14 bits.
// - Address and data share one two-way pin.
// - Host sends address as two one-of-ten codes.
// - Host picks operation with three mode pins.
// - Pin is input in address and data accept.
// - Device drives pin during shift-out.
// - Pin undriven in standby, read, erase, write.
// - Host supplies 14 kHz clock pacing all shifting.
// - Standby leaves address and data registers unchanged.
// - Standby keeps output driver off.
// - Code 011 shifts pin bit into address.
// - Read copies addressed word into data register.
// - Shift-out drives data register out per pulse.
// - Erase clears addressed word to zeros.
// - Code 111 shifts pin bits into data.
// - Data accept leaves address register unchanged.
// - Write stores data register at addressed word.
package earom_pkg;
  localparam int unsigned WORDS      = 100;
  localparam int unsigned WORD_W     = 14;
  localparam int unsigned FIELD_W    = 10;
  localparam int unsigned ADDR_W     = 2 * FIELD_W;
  localparam int unsigned INDEX_W    = 7;
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned SER_CLK_HZ = 14_000;
  // Half period of the serial clock in system cycles, rounded down
  localparam int unsigned SER_HALF_CYC = SYS_CLK_HZ / (2 * SER_CLK_HZ);
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [WORD_W-1:0] DATA_RST = 14'h0000;

  typedef enum logic [2:0] {
    MODE_STANDBY  = 3'h0,
    MODE_UNUSED   = 3'h1,
    MODE_ERASE    = 3'h2,
    MODE_ACC_ADDR = 3'h3,
    MODE_READ     = 3'h4,
    MODE_SHIFT    = 3'h5,
    MODE_WRITE    = 3'h6,
    MODE_ACC_DATA = 3'h7
  } mode_t;
endpackage

// *** test/earom_link_asserts.sv ***
// Purpose: Pin-level checks on the link between host and word store
// Assumes: HALF_CYC equals the host's serial half period
// Notes:   Device sees the pins about three cycles late
`timescale 1ns/1ps
module earom_link_asserts #(
  parameter int unsigned HALF_CYC = 8
) (
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Link
  input wire logic ser_clk,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic mode_select_c,
  input wire logic host_dat_o,
  input wire logic host_dat_oe,
  input wire logic dev_dat_o,
  input wire logic dev_dat_oe
);
  logic [2:0]  md;
  logic [15:0] hi_r;

  assign md = {mode_select_a, mode_select_b, mode_select_c};

  always_ff @(posedge clock) begin
    if (!rst_n)
      hi_r <= 16'h0000;
    else
      hi_r <= ser_clk ? hi_r + 16'h0001 : 16'h0000;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Six cycles covers the device's pin synchroniser
  sequence s_held(logic [2:0] c);
    (md == c)[*6];
  endsequence
  sequence s_not(logic [2:0] c);
    (md != c)[*6];
  endsequence

  a_shift_drives: assert property (s_held(3'h5) |-> dev_dat_oe)
    else $error("device idle on pin in shift-out");
  a_float_other: assert property (s_not(3'h5) |-> !dev_dat_oe)
    else $error("device drives pin outside shift-out");
  a_one_driver: assert property (!(host_dat_oe && dev_dat_oe))
    else $error("both ends drive the pin");
  a_host_accept: assert property ((md == 3'h3 || md == 3'h7) |-> host_dat_oe)
    else $error("host not driving during accept");
  a_host_quiet: assert property ((md inside {3'h0, 3'h2, 3'h4, 3'h5, 3'h6}) |->
    !host_dat_oe)
    else $error("host drives pin outside accept");
  a_mode_on_fall: assert property ($changed(md) |-> !ser_clk)
    else $error("mode changed while serial clock high");
  a_data_on_fall: assert property ($changed(host_dat_o) |-> !ser_clk)
    else $error("host data changed while serial clock high");
  a_half_period: assert property ($fell(ser_clk) |-> hi_r == HALF_CYC)
    else $error("serial clock high phase wrong length");
  a_shift_steady: assert property ((dev_dat_oe && $past(dev_dat_oe, 2) && !ser_clk &&
    !$past(ser_clk)) |-> $stable(dev_dat_o))
    else $error("shift-out bit moved in low phase");
endmodule

// *** test/serial_earom_mode_control_tb.sv ***
// Purpose: Drives both ends through write, read, erase and a full FIFO
// Assumes: Store contents are unknown until written
// Notes:   Short serial half period keeps the run brief
`timescale 1ns/1ps
module serial_earom_mode_control_tb;
  import earom_pkg::*;
  localparam int unsigned HC = 8;
  logic               clock     = 1'b0;
  logic               rst_n     = 1'b0;
  logic               cmd_valid = 1'b0;
  mode_t              cmd_op    = MODE_READ;
  logic [INDEX_W-1:0] cmd_addr  = '0;
  logic [WORD_W-1:0]  cmd_wdata = '0;
  logic               rsp_ready = 1'b0;
  logic               cmd_ready;
  logic               rsp_valid;
  logic               addr_ok;
  logic [2:0]         cur_mode;
  logic [WORD_W-1:0]  rsp_data;
  logic [WORD_W-1:0]  data_word;
  logic [ADDR_W-1:0]  adr_sh;
  logic [WORD_W-1:0]  din_sh;
  logic [WORD_W-1:0]  dout_sh;
  int                 errors    = 0;
  int                 cmp_count = 0;
  int                 cyc       = 0;

  earom_link_if lk ();
  assign lk.factory_test_pin = 1'b0;
  always #4 clock = ~clock;

  earom_dev i_earom_dev (.clock(clock), .rst_n(rst_n), .link(lk.dev),
    .cur_mode(cur_mode), .addr_ok(addr_ok), .data_word(data_word));
  earom_host #(.HALF_CYC(HC)) i_earom_host (.clock(clock), .rst_n(rst_n),
    .link(lk.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data));
  earom_link_asserts #(.HALF_CYC(HC)) i_earom_link_asserts (.clock(clock), .rst_n(rst_n),
    .ser_clk(lk.ser_clk), .mode_select_a(lk.mode_select_a),
    .mode_select_b(lk.mode_select_b), .mode_select_c(lk.mode_select_c),
    .host_dat_o(lk.host_dat_o), .host_dat_oe(lk.host_dat_oe),
    .dev_dat_o(lk.dev_dat_o), .dev_dat_oe(lk.dev_dat_oe));

  // Wire capture at each serial rise, per mode on the pins
  always @(posedge lk.ser_clk) begin
    case ({lk.mode_select_a, lk.mode_select_b, lk.mode_select_c})
      3'h3: adr_sh <= {adr_sh[ADDR_W-2:0], lk.dat};
      3'h7: din_sh <= {din_sh[WORD_W-2:0], lk.dat};
      3'h5: dout_sh <= {dout_sh[WORD_W-2:0], lk.dat};
      default: ;
    endcase
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic wait_rdy();
    for (int n = 0; n < 3000 && cmd_ready !== 1'b1; n++) tick();
    check(cmd_ready, 1'b1);
  endtask

  task automatic send(input mode_t op, input int unsigned a, input logic [WORD_W-1:0] d);
    wait_rdy();
    cmd_op = op;
    cmd_addr = a[INDEX_W-1:0];
    cmd_wdata = d;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
  endtask

  task automatic run(input mode_t op, input int unsigned a, input logic [WORD_W-1:0] d);
    send(op, a, d);
    wait_rdy();
  endtask

  task automatic pop(input logic [WORD_W-1:0] exp);
    for (int n = 0; n < 3000 && rsp_valid !== 1'b1; n++) tick();
    check(rsp_valid, 1'b1);
    check(rsp_data, exp);
    rsp_ready = 1'b1;
    tick();
    rsp_ready = 1'b0;
    // Let an edge pass so back-to-back pops never reassign in one step
    tick();
  endtask

  function automatic logic [ADDR_W-1:0] oh(input int unsigned a);
    return (20'h00001 << (10 + a / 10)) | (20'h00001 << (a % 10));
  endfunction

  task automatic t_reset();
    check(data_word, 14'h0000);
    check(addr_ok, 1'b0);
    check(lk.dev_dat_oe, 1'b0);
  endtask

  task automatic t_write_read(input int unsigned a, input logic [WORD_W-1:0] d);
    run(MODE_WRITE, a, d);
    check(adr_sh, oh(a));
    check(din_sh, d);
    check(data_word, d);
    check(addr_ok, 1'b1);
    run(MODE_READ, a, 14'h0000);
    check(dout_sh, d);
    // Zero fill: a full shift-out leaves the register empty
    check(data_word, 14'h0000);
    pop(d);
  endtask

  task automatic t_erase();
    run(MODE_ERASE, 57, 14'h0000);
    run(MODE_READ, 57, 14'h0000);
    pop(14'h0000);
    run(MODE_READ, 99, 14'h0000);
    pop(14'h15aa);
  endtask

  task automatic t_standby();
    run(MODE_WRITE, 99, 14'h15aa);
    repeat (300) tick();
    check(data_word, 14'h15aa);
    check(cur_mode, 3'h0);
    check(lk.dev_dat_oe, 1'b0);
    // Unused code acts as standby: data register and store untouched
    run(MODE_UNUSED, 0, 14'h0000);
    check(adr_sh, oh(0));
    check(data_word, 14'h15aa);
  endtask

  // Seventeenth read must stall until a word leaves the full FIFO
  task automatic t_fifo();
    for (int i = 0; i < 16; i++) run(MODE_READ, 99, 14'h0000);
    send(MODE_READ, 0, 14'h0000);
    repeat (800) tick();
    check(cmd_ready, 1'b0);
    for (int i = 0; i < 16; i++) pop(14'h15aa);
    pop(14'h2a55);
    wait_rdy();
    check(cmd_ready, 1'b1);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_write_read(0, 14'h2a55);
    t_write_read(99, 14'h15aa);
    t_write_read(57, 14'h3fff);
    t_erase();
    t_standby();
    t_fifo();
    summarize();
  end
endmodule
